// file: rfe_pkg.sv
// rf frame encoder: shared constants, state encoding and struct
// assumes a single 10 mhz system clock and no register bus
`default_nettype none
package rfe_pkg;
	// clock and timing
	localparam int SYS_CLK_HZ = 10000000;
	localparam int MOSC_DIV = 125; // medium osc edges per gap tick
	localparam int GAP_TICK_MS = 1; // nominal gap tick period
	localparam int MAX_STEP_MS = 63; // largest interval step
	// line format field codes
	localparam logic [1:0] FMT_MANCH = 2'h0;
	localparam logic [1:0] FMT_BIPH = 2'h1;
	localparam logic [1:0] FMT_NRZ = 2'h2;
	localparam logic [1:0] FMT_DIRECT = 2'h3;
	// field widths
	localparam int FRAME_W = 4;
	localparam int STEP_W = 6;
	localparam int GAP_W = 10; // holds 15 * 63 = 945
	localparam int DIV_W = 7;
	// reset values and divider last count
	localparam logic [DIV_W-1:0] DIV_RST = 7'h00;
	localparam logic [GAP_W-1:0] GAP_RST = 10'h000;
	localparam logic [FRAME_W-1:0] FRAME_RST = 4'h0;
	localparam logic [DIV_W-1:0] DIV_LAST = 7'(MOSC_DIV - 1);

	typedef enum logic [2:0] {
		RFE_IDLE = 3'b000,
		RFE_LOCK = 3'b001,
		RFE_TX = 3'b010,
		RFE_GAP = 3'b011
	} rfe_state_t;

	typedef struct packed {
		rfe_state_t st;
		logic send;
		logic phase; // 1: next tick starts a new bit
		logic cur_bit;
		logic cur_last;
		logic have_bit;
		logic line;
		logic done;
		logic [FRAME_W-1:0] frame_num;
		logic [GAP_W-1:0] gap_cnt;
		logic [GAP_W-1:0] gap_target;
		logic [DIV_W-1:0] div_cnt;
		logic mosc_prev;
		logic gap_tick;
	} rfe_regs_t;
endpackage
`default_nettype wire

// file: rfe_sync.sv
// rfe_sync: two flip-flop synchroniser for a level from outside the clock domain
// assumes the input is slow compared with sys_clk_in
`default_nettype none
module rfe_sync
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// level in and out
	input wire logic async_in,
	output logic sync_out
);
	logic meta_reg;
	logic sync_reg;

	// first stage feeds only the second
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule
`default_nettype wire

// file: rfe_encoder.sv
// rfe_encoder: transmit section of an rf transmitter - line coding,
// frame repetition with frame-number gaps, output stage gating and pll status
// assumes a half-bit tick pulse from an external bit-rate generator on the same
// clock, a bit stream from the rf data buffer, and asynchronous pll lock and
// medium oscillator inputs
`default_nettype none
// Function
// R1: between frames insert gap of step times frame number; none after last frame
// R2: gap timer ticks once per 125 medium oscillator cycles; step from control six
// R3: repeat count plus one frames are sent; zero sends one frame without gap
// R4: software sets interval step to zero when no gap is wanted
// R5: two-bit format picks manchester, bi-phase, nrz or direct; inversion flips it
// R6: format zero sends manchester with a transition mid-bit every bit
// R7: manchester, inversion clear: zero rises mid-bit, one falls mid-bit
// R8: manchester, inversion set: zero falls mid-bit, one rises mid-bit
// R9: manchester adds a start-of-bit transition when bit equals previous bit
// R10: format one sends bi-phase, toggling at every bit boundary
// R11: bi-phase, inversion clear: one no mid change, zero toggles mid-bit
// R12: bi-phase, inversion set: one toggles mid-bit, zero no mid change
// R13: format two holds one level per bit; inversion picks level for one
// R14: output data comes from buffer or software data bit by mode
// R15: output stage enabled only while transmit-go is set
// R16: lock-ready status raised once pll locked and transmission may start
// R17: keying select picks ook or fsk; fsk steers fractional-n divider
// R18: band select clear gives 315 mhz, set gives 434 mhz centre
// R19: keep-alive keeps transmitter digital section running in deepest stop
// R20: after the last frame clear transmit-go and raise an interrupt
// R21: gap tick is nominally one millisecond
// R22: format three passes the software data bit, only inversion applied
// R23: half-bit timing comes from a tick at twice the bit rate
module rfe_encoder
	import rfe_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// control bits
	input wire logic send_set_in,
	input wire logic send_clear_in,
	input wire logic [1:0] line_format_in,
	input wire logic output_inversion_in,
	input wire logic direct_data_in,
	input wire logic [FRAME_W-1:0] frame_repeat_count_in,
	input wire logic [STEP_W-1:0] interval_step_setting_in,
	input wire logic keying_select_in,
	input wire logic carrier_band_select_in,
	input wire logic rf_keepalive_enable_in,
	input wire logic deep_sleep_one_in,
	// timing
	input wire logic half_bit_tick_in,
	input wire logic medium_osc_in,
	// rf data buffer stream
	input wire logic buf_bit_in,
	input wire logic buf_last_in,
	input wire logic buf_valid_in,
	output logic buf_ready_out,
	// rf output stage
	input wire logic pll_locked_in,
	output logic pa_enable_out,
	output logic mod_data_out,
	output logic pll_fsk_out,
	output logic pll_band_434_out,
	output logic digital_power_on_out,
	// status
	output logic send_out,
	output logic pll_lock_ready_out,
	output logic gap_active_out,
	output logic [FRAME_W-1:0] frame_number_out,
	output logic tx_done_irq_out
);
	rfe_regs_t r_reg;
	rfe_regs_t r_next;
	logic lock_sync;
	logic mosc_sync;
	logic powered;
	logic take_bit;
	logic sym;
	logic [GAP_W-1:0] gap_goal;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	// pll lock and the oscillator come from outside the clock domain
	rfe_sync u_lock_sync
	(
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.async_in(pll_locked_in),
		.sync_out(lock_sync)
	);

	rfe_sync u_mosc_sync
	(
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.async_in(medium_osc_in),
		.sync_out(mosc_sync)
	);

	////////////////////////////////////////////////////////////////////////////
	// helper terms

	// digital section stays up in deep sleep only with keep-alive
	assign powered = !deep_sleep_one_in || rf_keepalive_enable_in; // R19
	// symbol value after inversion, shared by the manchester and nrz line codes
	assign sym = buf_bit_in ^ output_inversion_in; // R5
	// a new bit is taken on the tick that starts a bit period
	assign take_bit = (r_reg.st == RFE_TX) && half_bit_tick_in && r_reg.phase
		&& buf_valid_in && (line_format_in != FMT_DIRECT);
	// gap after frame n is n times the step, n counted from one
	assign gap_goal = GAP_W'(r_reg.frame_num + 4'h1) * GAP_W'(interval_step_setting_in); // R1

	////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb
	begin
		r_next = r_reg;
		r_next.done = 1'b0;
		r_next.gap_tick = 1'b0;
		r_next.mosc_prev = mosc_sync;

		// divide medium oscillator rising edges by 125 for a 1 ms tick
		if (mosc_sync && !r_reg.mosc_prev)
		begin
			if (r_reg.div_cnt == DIV_LAST) // R2
			begin
				r_next.div_cnt = DIV_RST;
				r_next.gap_tick = 1'b1; // R21
			end
			else
			begin
				r_next.div_cnt = r_reg.div_cnt + 7'h01;
			end
		end

		// software clear of transmit-go
		if (send_clear_in)
		begin
			r_next.send = 1'b0;
		end

		case (r_reg.st)
			RFE_IDLE:
			begin
				r_next.line = 1'b0;
				r_next.frame_num = FRAME_RST;
				r_next.phase = 1'b1;
				r_next.have_bit = 1'b0;
				if (r_reg.send && !send_clear_in)
				begin
					r_next.st = RFE_LOCK;
				end
			end
			RFE_LOCK:
			begin
				// wait for the pll before the first symbol
				if (lock_sync)
				begin
					r_next.st = RFE_TX; // R16
				end
			end
			RFE_TX:
			begin
				if (line_format_in == FMT_DIRECT)
				begin
					// software bit straight through, no line coding
					r_next.line = direct_data_in ^ output_inversion_in; // R22 R14
				end
				else if (half_bit_tick_in) // R23
				begin
					if (r_reg.phase)
					begin
						if (r_reg.have_bit && r_reg.cur_last)
						begin
							// frame complete at the end of its last bit
							r_next.have_bit = 1'b0;
							r_next.line = 1'b0;
							if (r_reg.frame_num == frame_repeat_count_in) // R3
							begin
								r_next.st = RFE_IDLE;
								r_next.send = 1'b0; // R20
								r_next.done = 1'b1; // R20
							end
							else if (gap_goal == GAP_RST)
							begin
								// zero step: next frame starts at once
								r_next.frame_num = r_reg.frame_num + 4'h1; // R1 R3
							end
							else
							begin
								r_next.st = RFE_GAP;
								r_next.gap_target = gap_goal;
								r_next.gap_cnt = GAP_RST;
								// restart the divider: a free-running one would cut the first tick short
								r_next.div_cnt = DIV_RST; // R21
								r_next.gap_tick = 1'b0;
							end
						end
						else if (take_bit)
						begin
							// first half of a new bit
							r_next.phase = 1'b0;
							r_next.have_bit = 1'b1;
							r_next.cur_bit = buf_bit_in;
							r_next.cur_last = buf_last_in;
							case (line_format_in)
								FMT_MANCH:
								begin
									// start edge appears by itself when bits repeat
									r_next.line = sym; // R6 R7 R8 R9
								end
								FMT_BIPH:
								begin
									r_next.line = !r_reg.line; // R10
								end
								FMT_NRZ:
								begin
									r_next.line = sym; // R13
								end
								default:
								begin
									r_next.line = r_reg.line;
								end
							endcase
						end
						else
						begin
							// buffer underrun: hold the line until data arrives
							r_next.line = r_reg.line;
						end
					end
					else
					begin
						// second half of the bit
						r_next.phase = 1'b1;
						case (line_format_in)
							FMT_MANCH:
							begin
								r_next.line = !r_reg.line; // R6 R7 R8
							end
							FMT_BIPH:
							begin
								// zero toggles unless inverted
								if (!(r_reg.cur_bit ^ output_inversion_in)) // R11 R12
								begin
									r_next.line = !r_reg.line;
								end
							end
							default:
							begin
								r_next.line = r_reg.line; // R13
							end
						endcase
					end
				end
			end
			RFE_GAP:
			begin
				r_next.line = 1'b0;
				if (r_reg.gap_tick)
				begin
					r_next.gap_cnt = r_reg.gap_cnt + 10'h001;
					if (r_reg.gap_cnt + 10'h001 >= r_reg.gap_target) // R1
					begin
						r_next.st = RFE_TX;
						r_next.phase = 1'b1;
						r_next.frame_num = r_reg.frame_num + 4'h1;
					end
				end
			end
			default:
			begin
				r_next.st = RFE_IDLE;
			end
		endcase

		// software set wins over a software or end-of-transfer clear in the same cycle, but not over loss of power
		if (send_set_in)
		begin
			r_next.send = 1'b1;
		end

		// software clear or loss of power aborts the sequence
		if (!r_next.send || !powered)
		begin
			if (r_reg.st != RFE_IDLE)
			begin
				r_next.st = RFE_IDLE;
				r_next.line = 1'b0;
			end
		end
		if (!powered)
		begin
			r_next.send = 1'b0; // R19
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			r_reg.st <= RFE_IDLE;
			r_reg.send <= 1'b0;
			r_reg.phase <= 1'b1;
			r_reg.cur_bit <= 1'b0;
			r_reg.cur_last <= 1'b0;
			r_reg.have_bit <= 1'b0;
			r_reg.line <= 1'b0;
			r_reg.done <= 1'b0;
			r_reg.frame_num <= FRAME_RST;
			r_reg.gap_cnt <= GAP_RST;
			r_reg.gap_target <= GAP_RST;
			r_reg.div_cnt <= DIV_RST;
			r_reg.mosc_prev <= 1'b0;
			r_reg.gap_tick <= 1'b0;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	// buffer handshake is combinational
	assign buf_ready_out = take_bit && !(r_reg.have_bit && r_reg.cur_last);
	// amplifier only runs while transmit-go is set
	assign pa_enable_out = r_reg.send && powered; // R15
	assign mod_data_out = r_reg.line;
	assign pll_fsk_out = keying_select_in; // R17
	assign pll_band_434_out = carrier_band_select_in; // R18
	assign digital_power_on_out = powered; // R19
	assign send_out = r_reg.send;
	assign pll_lock_ready_out = r_reg.send && lock_sync; // R16
	assign gap_active_out = (r_reg.st == RFE_GAP);
	assign frame_number_out = r_reg.frame_num;
	assign tx_done_irq_out = r_reg.done; // R20
endmodule
`default_nettype wire

// file: rfe_encoder_asserts.sv
// rfe_encoder_asserts: port-level checks on the rf frame encoder
// assumes it is bound to rfe_encoder, single clock domain
`default_nettype none
module rfe_encoder_asserts
	import rfe_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// watched inputs
	input wire logic send_set_in,
	input wire logic [1:0] line_format_in,
	input wire logic keying_select_in,
	input wire logic carrier_band_select_in,
	input wire logic rf_keepalive_enable_in,
	input wire logic deep_sleep_one_in,
	// watched outputs
	input wire logic buf_ready_out,
	input wire logic pa_enable_out,
	input wire logic mod_data_out,
	input wire logic pll_fsk_out,
	input wire logic pll_band_434_out,
	input wire logic digital_power_on_out,
	input wire logic send_out,
	input wire logic pll_lock_ready_out,
	input wire logic gap_active_out,
	input wire logic tx_done_irq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// end of transfer: one pulse, transmit-go gone right after
	sequence s_done_pulse;
		tx_done_irq_out ##1 !tx_done_irq_out;
	endsequence
	a_fsk_follows: assert property (pll_fsk_out == keying_select_in) else $error("fsk sel");
	a_band_follows: assert property (pll_band_434_out == carrier_band_select_in)
		else $error("band sel");
	a_power_keep: assert property (digital_power_on_out ==
		(!deep_sleep_one_in || rf_keepalive_enable_in)) else $error("power keep");
	a_pa_gated: assert property (pa_enable_out |-> send_out) else $error("pa without go");
	a_lock_gated: assert property (pll_lock_ready_out |-> send_out) else $error("lock rdy");
	a_set_takes: assert property (send_set_in |=> send_out) else $error("set lost");
	a_done_pulse: assert property (tx_done_irq_out |-> s_done_pulse) else $error("irq");
	a_done_clears: assert property (tx_done_irq_out |-> ##[0:1] !send_out)
		else $error("go not cleared");
	a_gap_quiet: assert property (gap_active_out && $past(gap_active_out) |-> !mod_data_out)
		else $error("line in gap");
	a_direct_nobuf: assert property (line_format_in == FMT_DIRECT |-> !buf_ready_out)
		else $error("buffer in direct");
endmodule
bind rfe_encoder rfe_encoder_asserts rfe_encoder_asserts_inst (.sys_clk_in, .rst_n_in,
	.send_set_in, .line_format_in, .keying_select_in, .carrier_band_select_in,
	.rf_keepalive_enable_in, .deep_sleep_one_in, .buf_ready_out, .pa_enable_out,
	.mod_data_out, .pll_fsk_out, .pll_band_434_out, .digital_power_on_out, .send_out,
	.pll_lock_ready_out, .gap_active_out, .tx_done_irq_out);
`default_nettype wire

// file: rfe_pll_model.sv
// rfe_pll_model: output stage pll that locks a while after enable
// assumes the enable comes from the encoder on sys_clk_in
`default_nettype none
module rfe_pll_model
#(
	parameter int LOCK_CYCLES = 5
)
(
	input wire logic sys_clk_in,
	input wire logic pa_enable_in,
	output var logic pll_locked_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial pll_locked_out = 1'b0;
	// never locked at once; lock drops as soon as enable goes
	always @(posedge sys_clk_in)
	begin
		cnt <= pa_enable_in ? cnt + 1 : 0;
		pll_locked_out <= pa_enable_in && (cnt >= LOCK_CYCLES);
	end
endmodule
`default_nettype wire

// file: rfe_encoder_tb_top.sv
// rfe_encoder_tb_top: directed tests of coding, frame repeat, gaps and control
// assumes rfe_encoder, rfe_pll_model and the checker are compiled before it
`default_nettype none
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %0t %s", $time, m); end end
module rfe_encoder_tb_top
	import rfe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int NB = 6;
	localparam logic [NB-1:0] PAT = 6'h1c; // bits 0,0,1,1,1,0 from index 0
	logic sys_clk_in = 0, rst_n_in = 0, send_set_in = 0, send_clear_in = 0;
	logic [1:0] line_format_in = 2'h0;
	logic output_inversion_in = 0, direct_data_in = 0, keying_select_in = 0;
	logic [FRAME_W-1:0] frame_repeat_count_in = 4'h0, frame_number_out, fseen = 4'h0;
	logic [STEP_W-1:0] interval_step_setting_in = 6'h00;
	logic carrier_band_select_in = 0, rf_keepalive_enable_in = 0, deep_sleep_one_in = 0;
	logic half_bit_tick_in = 0, medium_osc_in = 0, buf_bit_in, buf_last_in, buf_valid_in;
	logic buf_ready_out, pll_locked_in, pa_enable_out, mod_data_out, pll_fsk_out;
	logic pll_band_434_out, digital_power_on_out, send_out, pll_lock_ready_out;
	logic gap_active_out, tx_done_irq_out, en = 0, took = 0, started = 0;
	logic q[$];
	int fail_count = 0, check_count = 0, idx = 0, tcnt = 0, mcnt = 0, scnt = 0;
	int ntake = 0, gcnt = 0;
	rfe_encoder rfe_encoder_inst (.sys_clk_in, .rst_n_in, .send_set_in, .send_clear_in,
		.line_format_in, .output_inversion_in, .direct_data_in, .frame_repeat_count_in,
		.interval_step_setting_in, .keying_select_in, .carrier_band_select_in,
		.rf_keepalive_enable_in, .deep_sleep_one_in, .half_bit_tick_in, .medium_osc_in,
		.buf_bit_in, .buf_last_in, .buf_valid_in, .buf_ready_out, .pll_locked_in,
		.pa_enable_out, .mod_data_out, .pll_fsk_out, .pll_band_434_out,
		.digital_power_on_out, .send_out, .pll_lock_ready_out, .gap_active_out,
		.frame_number_out, .tx_done_irq_out);
	rfe_pll_model #(.LOCK_CYCLES(5)) rfe_pll_model_inst (.sys_clk_in,
		.pa_enable_in(pa_enable_out), .pll_locked_out(pll_locked_in));
	////////////////////////////////////////////////////////////////////////////////
	always #50 sys_clk_in = ~sys_clk_in;
	// buffer stream restarts per frame so every frame carries the same pattern
	assign buf_bit_in = PAT[idx % NB];
	assign buf_last_in = (idx == NB - 1);
	assign buf_valid_in = en && (idx < NB);
	// half-bit tick every 6 cycles, oscillator period 80 cycles (8 us)
	always @(negedge sys_clk_in)
	begin
		tcnt <= (tcnt == 5) ? 0 : tcnt + 1;
		half_bit_tick_in <= (tcnt == 5);
		mcnt <= (mcnt == 39) ? 0 : mcnt + 1;
		if (mcnt == 39)
			medium_osc_in <= ~medium_osc_in;
		if (took)
			idx <= idx + 1;
		if (!send_out || frame_number_out != fseen)
			idx <= 0;
		fseen <= frame_number_out;
		if (scnt == 1)
			q.push_back(mod_data_out);
		if (gap_active_out)
			gcnt <= gcnt + 1;
	end
	// a line sample sits mid-way into each half-bit once the first bit went out
	always @(posedge sys_clk_in)
	begin
		took <= half_bit_tick_in && buf_valid_in && buf_ready_out;
		if (half_bit_tick_in && buf_valid_in && buf_ready_out)
			ntake <= ntake + 1;
		if (half_bit_tick_in && buf_valid_in && buf_ready_out)
			started <= 1;
		scnt <= (half_bit_tick_in && (started || buf_valid_in && buf_ready_out)) ? 3 :
			(scnt > 0 ? scnt - 1 : 0);
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic pulse_set();
		@(negedge sys_clk_in) send_set_in = 1;
		@(negedge sys_clk_in) send_set_in = 0;
	endtask
	// one buffer transfer; waits for the done pulse under a bound
	task automatic run_tx(input logic [1:0] f, input logic v, input int rep, input int st);
		int n;
		n = 0;
		@(negedge sys_clk_in);
		line_format_in = f;
		output_inversion_in = v;
		frame_repeat_count_in = 4'(rep);
		interval_step_setting_in = 6'(st);
		q = {};
		// a sample still counting down from the last run must not land in q
		scnt = 0;
		started = 0;
		ntake = 0;
		gcnt = 0;
		en = 1;
		pulse_set();
		while (tx_done_irq_out !== 1'b1 && n < 40000)
		begin
			@(negedge sys_clk_in);
			n++;
		end
		`CHK(n < 40000, 1'b1, "no done pulse")
		repeat (3) @(negedge sys_clk_in);
		`CHK(send_out, 1'b0, "go still set")
		`CHK(ntake, NB * (rep + 1), "frame count")
	endtask
	task automatic check_code(input logic [1:0] f, input logic v);
		logic d, a, b, prev;
		prev = 0;
		run_tx(f, v, 0, 0);
		for (int i = 0; i < NB; i++)
		begin
			d = PAT[i] ^ v;
			a = (f == FMT_BIPH) ? ~prev : d;
			b = (f == FMT_MANCH) ? ~d : ((f == FMT_BIPH) ? (d ? a : ~a) : d);
			prev = b;
			`CHK(q[2 * i], a, "first half")
			`CHK(q[2 * i + 1], b, "second half")
		end
		`CHK(gcnt, 0, "gap after single frame")
		$display("test code %0d inv %0d done", f, v);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// watchdog: the tests need about 12000 cycles
	initial
	begin
		repeat (60000) @(posedge sys_clk_in);
		fail_count++;
		conclude();
	end
	initial
	begin
		repeat (12) @(negedge sys_clk_in);
		rst_n_in = 1;
		for (int c = 0; c < 6; c++)
			check_code(2'(c / 2), 1'(c % 2));
		run_tx(FMT_NRZ, 0, 15, 0);
		`CHK(gcnt, 0, "gap with zero step")
		run_tx(FMT_NRZ, 1, 1, 1);
		`CHK(gcnt > 9800 && gcnt < 10200, 1'b1, "gap length")
		$display("test frames done");
		line_format_in = FMT_DIRECT;
		en = 0;
		keying_select_in = 1;
		carrier_band_select_in = 1;
		pulse_set();
		repeat (20) @(negedge sys_clk_in);
		`CHK(pa_enable_out, 1'b1, "pa off")
		`CHK(pll_lock_ready_out, 1'b1, "no lock ready")
		`CHK(pll_fsk_out, 1'b1, "fsk select")
		`CHK(pll_band_434_out, 1'b1, "band select")
		for (int d = 0; d < 2; d++)
		begin
			direct_data_in = 1'(d);
			repeat (4) @(negedge sys_clk_in);
			`CHK(mod_data_out, 1'(d) ^ output_inversion_in, "direct bit")
		end
		// software clear of transmit-go shuts the stage, a new set restarts it
		send_clear_in = 1;
		@(negedge sys_clk_in) send_clear_in = 0;
		@(negedge sys_clk_in);
		`CHK(send_out, 1'b0, "clear ignored")
		`CHK(pa_enable_out, 1'b0, "pa after clear")
		pulse_set();
		repeat (20) @(negedge sys_clk_in);
		`CHK(pa_enable_out, 1'b1, "pa after set")
		rf_keepalive_enable_in = 1;
		deep_sleep_one_in = 1;
		repeat (4) @(negedge sys_clk_in);
		`CHK(send_out, 1'b1, "keepalive lost go")
		`CHK(digital_power_on_out, 1'b1, "keepalive power")
		rf_keepalive_enable_in = 0;
		repeat (4) @(negedge sys_clk_in);
		`CHK(pa_enable_out, 1'b0, "pa on in sleep")
		`CHK(digital_power_on_out, 1'b0, "power in sleep")
		$display("test direct done");
		conclude();
	end
endmodule
`default_nettype wire
